//--- design/smc_nvm_if.sv
// Purpose: Link between the channel sequencer and the nonvolatile channel store.
// Assumes: One clock; read data returns one cycle after the read address.
// Notes:   Control side drives everything except rd_data and boot_ch.
`timescale 1ns/1ns
interface smc_nvm_if;
  import smc_pkg::*;
  logic [1:0]           rd_ch;
  logic [SMC_IDX_W-1:0] rd_idx;
  logic [31:0]          rd_data;
  logic                 wr_en;
  logic [1:0]           wr_ch;
  logic [SMC_IDX_W-1:0] wr_idx;
  logic [31:0]          wr_data;
  logic                 start_save;
  logic                 commit;
  logic                 set_boot;
  logic [1:0]           boot_sel;
  logic [1:0]           boot_ch;

  modport ctrl  (output rd_ch, rd_idx, wr_en, wr_ch, wr_idx, wr_data, start_save, commit,
                 set_boot, boot_sel, input rd_data, boot_ch);
  modport store (input rd_ch, rd_idx, wr_en, wr_ch, wr_idx, wr_data, start_save, commit,
                 set_boot, boot_sel, output rd_data, boot_ch);
endinterface

//--- design/smc_nvm_store.sv
// Purpose: Nonvolatile settings channels: a fixed factory channel and user channels.
// Assumes: Contents survive the logic reset, so nothing here is reset.
// Notes:   A user channel is valid only once a full save has committed.
`timescale 1ns/1ns
module smc_nvm_store #(
  parameter int WORDS = smc_pkg::SMC_IMAGE_WORDS
) (
  input wire logic   core_clk,
  smc_nvm_if.store   nv
);
  import smc_pkg::*;

  logic [31:0]                  mem_r [SMC_USER_CHANNELS][WORDS];
  logic [SMC_USER_CHANNELS:1]   valid_r = '0;
  logic [1:0]                   boot_r  = SMC_FACTORY_CH;
  logic [31:0]                  rd_data_r;
  logic                         rd_user;
  logic                         wr_user;

  // Factory channel and unfinished images both read as factory words
  assign rd_user = (nv.rd_ch != SMC_FACTORY_CH) && valid_r[nv.rd_ch];
  assign wr_user = nv.wr_en && (nv.wr_ch != SMC_FACTORY_CH) && (nv.wr_ch <= SMC_LAST_USER_CH);
  assign nv.rd_data = rd_data_r;
  assign nv.boot_ch = boot_r;

  // Registered read port
  always_ff @(posedge core_clk) begin
    rd_data_r <= rd_user ? mem_r[1'(nv.rd_ch - 2'h1)][nv.rd_idx] : SMC_FACTORY_WORD;
  end

  // R1 factory never written
  always_ff @(posedge core_clk) begin
    if (wr_user) begin
      mem_r[1'(nv.wr_ch - 2'h1)][nv.wr_idx] <= nv.wr_data;
    end
  end

  // R7 valid only after commit
  always_ff @(posedge core_clk) begin
    if (nv.start_save) begin
      valid_r[nv.wr_ch] <= 1'b0;
    end else if (nv.commit) begin
      valid_r[nv.wr_ch] <= 1'b1;
    end
  end

  // R3 boot source tracks last save
  always_ff @(posedge core_clk) begin
    if (nv.commit) begin
      boot_r <= nv.wr_ch;
    end else if (nv.set_boot) begin
      boot_r <= nv.boot_sel;
    end
  end

endmodule

//--- design/smc_pkg.sv
// Purpose: Shared constants and types for the settings memory channel block.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus, one word per register.
// Notes:   Offsets of the saved image are kept in save order.
package smc_pkg;

  // Bus and channel geometry
  localparam int          SMC_ADR_W         = 16;
  localparam int          SMC_IMAGE_WORDS   = 48;
  localparam int          SMC_IDX_W         = 6;
  localparam int          SMC_USER_CHANNELS = 2;
  localparam logic [1:0]  SMC_FACTORY_CH    = 2'h0;
  localparam logic [1:0]  SMC_LAST_USER_CH  = 2'h2;
  localparam logic [31:0] SMC_FACTORY_WORD  = 32'h0000_0000;

  // Channel control registers
  localparam logic [15:0] SMC_SAVE_CMD_OFS  = 16'h0618;
  localparam logic [15:0] SMC_SAVE_CH_OFS   = 16'h0620;
  localparam logic [15:0] SMC_ACTIVE_CH_OFS = 16'h0624;
  localparam logic [15:0] SMC_REINIT_OFS    = 16'h0630;
  localparam int          SMC_REINIT_BIT    = 0;

  // Saved image, from the frame-rate register through the frame details register
  localparam logic [15:0] SMC_IMAGE_OFS [SMC_IMAGE_WORDS] = '{
    16'h0600, 16'h0604, 16'h0608, 16'h0610, 16'h0620, 16'h0800, 16'h0804, 16'h0808,
    16'h080C, 16'h0810, 16'h0814, 16'h0818, 16'h081C, 16'h0820, 16'h0824, 16'h0828,
    16'h0830, 16'h0834, 16'h083C, 16'h0884, 16'h0888, 16'h0908, 16'h0918, 16'h0928,
    16'h0938, 16'h0948, 16'h0958, 16'h0968, 16'h1048, 16'h1088, 16'h1098, 16'h10A0,
    16'h1104, 16'h1108, 16'h110C, 16'h1110, 16'h1114, 16'h1118, 16'h1120, 16'h1124,
    16'h1128, 16'h1130, 16'h1134, 16'h1138, 16'h1140, 16'h1144, 16'h1148, 16'h12F8};
  localparam logic [SMC_IDX_W-1:0] SMC_SAVE_CH_IDX = 6'h04;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SAVE} smc_state_e;

  // Address to image slot: bit 6 is the hit flag, low bits the slot
  function automatic logic [SMC_IDX_W:0] smc_img_find(input logic [SMC_ADR_W-1:0] adr);
    logic [SMC_IDX_W:0] res;
    res = '0;
    for (int i = 0; i < SMC_IMAGE_WORDS; i++) begin
      if (adr == SMC_IMAGE_OFS[i]) begin
        res = {1'b1, SMC_IDX_W'(i)};
      end
    end
    return res;
  endfunction

  // Byte lane selects widened to a bit mask
  function automatic logic [31:0] smc_lane_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

endpackage

//--- design/smc_top.sv
// Purpose: Settings memory channels behind a classic Wishbone slave.
// Assumes: Single 125 MHz clock, synchronous active-high reset as reinitialisation.
// Notes:   Bus accesses stall (no ack) while a load or save sequence runs.
// How it works
// R1 - Channel 0 holds the factory settings, is never written, and can always be loaded.
// R2 - Channels 1 and 2 are the only writable channels, each holding a whole image.
// R3 - After reset or a reinit request the image is loaded from the boot channel: the last saved one, or the one last written to 0x624.
// R4 - A save aimed at channel 0 writes nothing and makes channel 0 the boot source.
// R5 - Save command sits at 0x618, save target at 0x620 and the active channel at 0x624.
// R6 - The image is the fixed list of registers from 0x600 through 0x12F8, strobe ones too.
// R7 - A save copies every image register, and a partial image is never loaded.
`timescale 1ns/1ns
module smc_top (
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [smc_pkg::SMC_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  output logic                               settings_busy
);
  import smc_pkg::*;

  localparam int WORDS = SMC_IMAGE_WORDS;
  localparam logic [SMC_IDX_W-1:0] LAST_IDX = SMC_IDX_W'(WORDS - 1);
  localparam logic [SMC_IDX_W-1:0] END_IDX  = SMC_IDX_W'(WORDS);

  smc_nvm_if nv ();

  smc_nvm_store #(.WORDS(WORDS)) u_store (
    .core_clk (core_clk),
    .nv       (nv.store)
  );

  smc_state_e           state_r;
  smc_state_e           state_nxt;
  logic [SMC_IDX_W-1:0] idx_r;
  logic [SMC_IDX_W-1:0] idx_nxt;
  logic [31:0]          live_r [WORDS];
  logic [1:0]           active_ch_r;
  logic [1:0]           save_ch_r;
  logic                 ack_r;
  logic [31:0]          dat_r;

  // Bus decode
  logic                 idle;
  logic                 take;
  logic                 take_wr;
  logic [SMC_IDX_W:0]   img_find;
  logic                 hit_img;
  logic [SMC_IDX_W-1:0] img_idx;
  logic                 is_save;
  logic                 is_act;
  logic                 is_reinit;
  logic [1:0]           save_tgt;
  logic                 tgt_user;
  logic                 save_go;
  logic                 save_factory;
  logic                 act_wr;
  logic                 reinit_go;
  logic [31:0]          lane_mask;
  logic [31:0]          rd_word;

  assign idle         = (state_r == ST_IDLE);
  assign take         = wb_cyc_i && wb_stb_i && !ack_r && idle;
  assign take_wr      = take && wb_we_i;
  assign img_find     = smc_img_find(wb_adr_i);
  assign hit_img      = img_find[SMC_IDX_W];
  assign img_idx      = img_find[SMC_IDX_W-1:0];
  // R5 control register decode
  assign is_save      = (wb_adr_i == SMC_SAVE_CMD_OFS);
  assign is_act       = (wb_adr_i == SMC_ACTIVE_CH_OFS);
  assign is_reinit    = (wb_adr_i == SMC_REINIT_OFS);
  assign save_tgt     = live_r[SMC_SAVE_CH_IDX][1:0];
  // R2 only two user channels
  assign tgt_user     = (save_tgt != SMC_FACTORY_CH) && (save_tgt <= SMC_LAST_USER_CH);
  assign save_go      = take_wr && is_save && tgt_user;
  // R4 factory save marks boot only
  assign save_factory = take_wr && is_save && (save_tgt == SMC_FACTORY_CH);
  assign act_wr       = take_wr && is_act && wb_sel_i[0] && (wb_dat_i[1:0] <= SMC_LAST_USER_CH);
  assign reinit_go    = take_wr && is_reinit && wb_sel_i[0] && wb_dat_i[SMC_REINIT_BIT];
  assign lane_mask    = smc_lane_mask(wb_sel_i);

  // Read mux; the save command is write-only and reads zero
  assign rd_word = is_act    ? {30'h0, active_ch_r} :
                   is_reinit ? {31'h0, !idle} :
                   hit_img   ? live_r[img_idx] : 32'h0;

  // Store side of the sequencer
  assign nv.rd_ch      = nv.boot_ch;
  assign nv.rd_idx     = idx_r;
  assign nv.wr_en      = (state_r == ST_SAVE);
  assign nv.wr_ch      = save_go ? save_tgt : save_ch_r;
  assign nv.wr_idx     = idx_r;
  assign nv.wr_data    = live_r[idx_r];
  assign nv.start_save = save_go;
  assign nv.commit     = (state_r == ST_SAVE) && (idx_r == LAST_IDX);
  assign nv.set_boot   = save_factory || act_wr;
  assign nv.boot_sel   = save_factory ? SMC_FACTORY_CH : wb_dat_i[1:0];

  assign wb_ack_o      = ack_r;
  assign wb_dat_o      = dat_r;
  assign settings_busy = !idle;

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    unique case (state_r)
      ST_IDLE: begin
        idx_nxt = '0;
        if (save_go) begin
          state_nxt = ST_SAVE;
        end else if (reinit_go) begin
          state_nxt = ST_LOAD;
        end
      end
      ST_LOAD: begin
        idx_nxt = idx_r + 6'h01;
        if (idx_r == END_IDX) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_SAVE: begin
        idx_nxt = idx_r + 6'h01;
        if (idx_r == LAST_IDX) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // R3 reset starts a load
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= ST_LOAD;
      idx_r   <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
    end
  end

  // Target latched so a rewrite of 0x620 mid-save cannot split the image
  always_ff @(posedge core_clk) begin
    if (reset) begin
      save_ch_r <= SMC_FACTORY_CH;
    end else if (save_go) begin
      save_ch_r <= save_tgt;
    end
  end

  // R3 active channel set at load end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      active_ch_r <= SMC_FACTORY_CH;
    end else if (state_r == ST_LOAD && idx_r == END_IDX) begin
      active_ch_r <= nv.boot_ch;
    end
  end

  // R6 live image registers: loaded from store, or written with byte lanes
  always_ff @(posedge core_clk) begin
    if (state_r == ST_LOAD && idx_r != '0) begin
      live_r[idx_r - 6'h01] <= nv.rd_data;
    end else if (take_wr && hit_img) begin
      live_r[img_idx] <= (live_r[img_idx] & ~lane_mask) | (wb_dat_i & lane_mask);
    end
  end

  // Registered ack one cycle after a taken request; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= take;
      dat_r <= (take && !wb_we_i) ? rd_word : 32'h0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_no_factory_write;
    nv.wr_en |-> nv.wr_ch != SMC_FACTORY_CH;
  endproperty
  a_no_factory_write: assert property (p_no_factory_write) else $error("factory written"); // R1

  property p_user_range;
    nv.start_save |=> nv.wr_en && nv.wr_ch inside {2'h1, 2'h2};
  endproperty
  a_user_range: assert property (p_user_range) else $error("bad user channel"); // R2

  property p_boot_load;
    $fell(reset) |-> settings_busy [*8];
  endproperty
  a_boot_load: assert property (p_boot_load) else $error("no load after reset"); // R3

  property p_load_source;
    (state_r == ST_LOAD && idx_r == END_IDX) |=> active_ch_r == $past(nv.boot_ch);
  endproperty
  a_load_source: assert property (p_load_source) else $error("wrong load source"); // R3

  property p_factory_save;
    save_factory |=> !nv.wr_en && nv.boot_ch == SMC_FACTORY_CH;
  endproperty
  a_factory_save: assert property (p_factory_save) else $error("factory save wrong"); // R4

  property p_active_read;
    (take && !wb_we_i && is_act) |=> wb_ack_o && wb_dat_o == {30'h0, active_ch_r};
  endproperty
  a_active_read: assert property (p_active_read) else $error("active read wrong"); // R5

  property p_image_write;
    (take_wr && hit_img && wb_sel_i == 4'hF) |=> live_r[$past(img_idx)] == $past(wb_dat_i);
  endproperty
  a_image_write: assert property (p_image_write) else $error("image write lost"); // R6

  property p_full_save;
    nv.commit |-> nv.wr_en && nv.wr_idx == LAST_IDX && $past(nv.wr_en, 8);
  endproperty
  a_full_save: assert property (p_full_save) else $error("partial save"); // R7

  c_save_done:    cover property (nv.commit);
  c_factory_save: cover property (save_factory);
  c_reinit:       cover property (reinit_go ##[1:60] idle);
  c_active_wr:    cover property (act_wr);

endmodule

//--- sim/settings_memory_channels_tb.sv
// Purpose: Self-checking bench for the settings memory channel block.
// Assumes: Channel store starts blank, so the first load gives factory words.
// Notes:   Index 3 of the expected table is scratch, never saved.
`timescale 1ns/1ns
module settings_memory_channels_tb;
  import smc_pkg::*;
  logic                 core_clk;
  logic                 reset;
  logic                 wb_cyc_i;
  logic                 wb_stb_i;
  logic                 wb_we_i;
  logic [SMC_ADR_W-1:0] wb_adr_i;
  logic [3:0]           wb_sel_i;
  logic [31:0]          wb_dat_i;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  logic                 settings_busy;
  logic [31:0]          img [4][SMC_IMAGE_WORDS];
  logic [31:0]          q;
  int                   bad_count;
  int                   cmp_count;
  int                   cyc_count;
  integer               seed;

  smc_top DUT (.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .settings_busy(settings_busy));

  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Cut a hang short; loads stall the bus, so allow generous room
  initial begin
    cyc_count = 0;
    forever begin
      @(posedge core_clk);
      cyc_count++;
      if (cyc_count == 20000) begin
        bad_count++;
        test_done();
      end
    end
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle; holds everything until ack is sampled high
  task automatic bus(input logic we, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd_q);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 300);
    rd_q = wb_dat_o;
    if (n >= 300) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(q, e);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF, q);
  endtask

  // Random image into slot k, save target field set to ch
  task automatic fill(input int k, input logic [1:0] ch);
    for (int i = 0; i < SMC_IMAGE_WORDS; i++) begin
      img[k][i] = $random(seed);
      if (i == SMC_SAVE_CH_IDX) img[k][i] = {30'h0, ch};
      wr(SMC_IMAGE_OFS[i], img[k][i]);
    end
  endtask

  task automatic save(input logic [1:0] ch);
    fill(ch, ch);
    wr(SMC_SAVE_CMD_OFS, $random(seed));
    @(posedge core_clk);
    // Busy only while a user copy runs
    chk({31'h0, settings_busy}, {31'h0, ch != SMC_FACTORY_CH});
    // Factory channel keeps its words whatever was live
    if (ch == SMC_FACTORY_CH) begin
      for (int i = 0; i < SMC_IMAGE_WORDS; i++) img[0][i] = SMC_FACTORY_WORD;
    end
  endtask

  task automatic cmp_all(input int k);
    for (int i = 0; i < SMC_IMAGE_WORDS; i++) begin
      rd(SMC_IMAGE_OFS[i], img[k][i]);
    end
  endtask

  // Reload request; the next access waits out the load
  task automatic reinit();
    wr(SMC_REINIT_OFS, 32'h0000_0001);
  endtask

  // One-edge reset in mid-run, as a power-up reload
  task automatic boot_pulse();
    @(posedge core_clk);
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
  endtask

  initial begin
    seed = 32'h7BC3;
    bad_count = 0;
    cmp_count = 0;
    reset = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = '0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    for (int i = 0; i < SMC_IMAGE_WORDS; i++) img[0][i] = SMC_FACTORY_WORD;
    repeat (12) @(posedge core_clk);
    chk({31'h0, settings_busy}, 32'h1);
    reset <= 1'b0;
    rd(SMC_ACTIVE_CH_OFS, 32'h0);
    cmp_all(0);
    rd(SMC_SAVE_CMD_OFS, 32'h0);
    rd(16'h0700, 32'h0);
    rd(SMC_REINIT_OFS, 32'h0);
    save(2'h1);
    fill(3, 2'h3);
    // Target 3 is no channel: save is ignored
    wr(SMC_SAVE_CMD_OFS, 32'h0);
    chk({31'h0, settings_busy}, 32'h0);
    reinit();
    cmp_all(1);
    rd(SMC_ACTIVE_CH_OFS, 32'h1);
    save(2'h2);
    // Power-up style reload from the newest channel, once the copy is done
    while (settings_busy) @(posedge core_clk);
    boot_pulse();
    cmp_all(2);
    rd(SMC_ACTIVE_CH_OFS, 32'h2);
    // Channel 3 does not exist, so the boot source stays at 2
    wr(SMC_ACTIVE_CH_OFS, 32'h3);
    reinit();
    rd(SMC_ACTIVE_CH_OFS, 32'h2);
    wr(SMC_ACTIVE_CH_OFS, 32'h1);
    reinit();
    cmp_all(1);
    rd(SMC_ACTIVE_CH_OFS, 32'h1);
    // Byte lanes on an image register
    wr(16'h0800, 32'hA5A5_1234);
    bus(1'b1, 16'h0800, 32'h0F0F_BEEF, 4'h3, q);
    rd(16'h0800, 32'hA5A5_BEEF);
    save(2'h0);
    reinit();
    cmp_all(0);
    rd(SMC_ACTIVE_CH_OFS, 32'h0);
    wr(SMC_ACTIVE_CH_OFS, 32'h1);
    reinit();
    cmp_all(1);
    // Save cut by reset: old channel still boots, cut channel reads factory
    fill(2, 2'h2);
    wr(SMC_SAVE_CMD_OFS, 32'h0);
    repeat (5) @(posedge core_clk);
    boot_pulse();
    cmp_all(1);
    rd(SMC_ACTIVE_CH_OFS, 32'h1);
    wr(SMC_ACTIVE_CH_OFS, 32'h2);
    reinit();
    cmp_all(0);
    rd(SMC_ACTIVE_CH_OFS, 32'h2);
    test_done();
  end
endmodule
